// ===== design/rco_pkg.sv
package rco_pkg;

  // ****************************************************************
  // Frame layout and parser constants
  // ****************************************************************
  localparam logic [15:0] HDR_LEN = 16'h000E;
  localparam logic [15:0] TYPE_POS = 16'h000C;
  localparam logic [15:0] TAG_LEN = 16'h0004;
  localparam logic [15:0] TYPE_LEN = 16'h0002;
  localparam logic [15:0] SNAP_SKIP = 16'h000A;
  localparam logic [15:0] SNAP_CHK_OFS = 16'h0004;
  localparam logic [15:0] LEN_LIMIT = 16'h0600;
  localparam logic [15:0] FCS_LEN = 16'h0004;
  localparam logic [15:0] CSUM_LEN = 16'h0002;
  localparam logic [15:0] START_NONE = 16'hFFFF;
  localparam logic [7:0] LLC_SAP = 8'hAA;
  localparam logic [7:0] LLC_UI = 8'h03;
  localparam logic [1:0] MAX_TAGS = 2'h2;
  localparam logic [15:0] TPID_RESET = 16'h8100;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_FOLD = 2'b01,
    ST_APP_LO = 2'b10,
    ST_APP_HI = 2'b11
  } rco_state_e;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } rco_byte_s;

  typedef struct packed {
    logic valid;
    logic [15:0] length;
  } rco_len_s;

  typedef struct packed {
    rco_state_e st;
    rco_byte_s out;
    rco_len_s len;
    logic ready;
    logic in_frame;
    logic en;
    logic mode;
    logic [15:0] pos;
    logic [15:0] type_pos;
    logic [1:0] tags;
    logic snap_chk;
    logic [15:0] start;
    logic [3:0][7:0] hist;
    logic [15:0] sum;
    logic [7:0] low;
    logic half;
  } rco_regs_s;

endpackage

// ===== design/rco_rx_checksum_engine.sv
`timescale 1ns/1ps
// How it works
// (RULE_01) Mode 0 sums bytes after the 14 header bytes, excluding the FCS.
// (RULE_02) Mode 1 skips VLAN tags and SNAP header, summing from layer-3 start.
// (RULE_03) A VLAN tag is a type field equal to the programmable tag value.
// (RULE_04) At most two tags parsed; a third tag acts as type field.
// (RULE_05) The 16-bit sum is appended right after the last frame byte.
// (RULE_06) Reported frame length grows by two bytes when the sum is appended.
// (RULE_07) Checksum only while enabled, per mode bit; else data passes unchanged.
// (RULE_08) Software halts and flushes receive before changing enable or mode.
// (RULE_09) Software never enables checksum offload and pad stripping together.
// (RULE_10) Bytes summed as 16-bit words; an odd last byte pairs with zero.
// (RULE_11) Later byte of a pair is the upper byte, earlier the lower.
// (RULE_12) Carry of every addition is added back into the running sum.
// (RULE_13) Appended sum is not inverted and restarts with each frame.
// (RULE_14) Enable and mode are sampled only at the first byte of a frame.
module rco_rx_checksum_engine (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic rx_checksum_enable_in,
  input wire logic rx_checksum_mode_select_in,
  input wire logic [15:0] first_vlan_tag_type_in,
  input wire rco_pkg::rco_byte_s rx_byte_in,
  output logic rx_ready_out,
  output rco_pkg::rco_byte_s dma_byte_out,
  output rco_pkg::rco_len_s frame_length_field_out
);

  // ****************************************************************
  // End-around-carry adder
  // ****************************************************************
  function automatic logic [15:0] add_eac(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] t;
    t = {1'b0, a} + {1'b0, b};
    return t[15:0] + {15'h0000, t[16]}; // RULE_12
  endfunction

  rco_pkg::rco_regs_s s;
  rco_pkg::rco_regs_s next_s;
  logic take;
  logic first;
  logic en_eff;
  logic [15:0] type_word;
  logic [15:0] q;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    next_s = s;
    take = rx_byte_in.valid & s.ready & (s.st == rco_pkg::ST_RUN);
    first = ~s.in_frame;
    en_eff = first ? rx_checksum_enable_in : s.en;
    type_word = {s.hist[0], rx_byte_in.data};
    q = s.pos - rco_pkg::FCS_LEN;
    next_s.out.valid = 1'b0;
    next_s.out.last = 1'b0;
    next_s.len.valid = 1'b0;
    unique case (s.st)
      rco_pkg::ST_RUN: begin
        if (take) begin
          next_s.out.valid = 1'b1; // RULE_07
          next_s.out.data = rx_byte_in.data;
          next_s.out.last = rx_byte_in.last & ~en_eff;
          next_s.hist = {s.hist[2:0], rx_byte_in.data};
          next_s.pos = s.pos + 16'h0001;
          next_s.in_frame = ~rx_byte_in.last;
          if (first) begin
            next_s.en = rx_checksum_enable_in; // RULE_14
            next_s.mode = rx_checksum_mode_select_in; // RULE_14
            next_s.pos = 16'h0001;
            next_s.type_pos = rco_pkg::TYPE_POS;
            next_s.tags = 2'h0;
            next_s.snap_chk = 1'b0;
            next_s.start = rx_checksum_mode_select_in ? rco_pkg::START_NONE : rco_pkg::HDR_LEN; // RULE_01
            next_s.sum = 16'h0000; // RULE_13
            next_s.half = 1'b0;
          end else begin
            // Mode 1 parser works on the incoming byte, ahead of the summing tap
            if (s.mode && s.start == rco_pkg::START_NONE) begin
              if (s.pos == s.type_pos + 16'h0001 && !s.snap_chk) begin
                if (type_word == first_vlan_tag_type_in && s.tags != rco_pkg::MAX_TAGS) begin
                  next_s.tags = s.tags + 2'h1; // RULE_03
                  next_s.type_pos = s.type_pos + rco_pkg::TAG_LEN; // RULE_04
                end else if (type_word < rco_pkg::LEN_LIMIT) begin
                  next_s.snap_chk = 1'b1;
                end else begin
                  next_s.start = s.type_pos + rco_pkg::TYPE_LEN; // RULE_04
                end
              end
              if (s.snap_chk && s.pos == s.type_pos + rco_pkg::SNAP_CHK_OFS) begin
                if (s.hist[1] == rco_pkg::LLC_SAP && s.hist[0] == rco_pkg::LLC_SAP && rx_byte_in.data == rco_pkg::LLC_UI) begin
                  next_s.start = s.type_pos + rco_pkg::SNAP_SKIP; // RULE_02
                end else begin
                  next_s.start = s.type_pos + rco_pkg::TYPE_LEN;
                end
              end
            end
            // Oldest held byte is summed only once four newer bytes exist, so FCS never enters
            if (s.pos >= rco_pkg::FCS_LEN && q >= s.start) begin // RULE_01
              if (!s.half) begin
                next_s.low = s.hist[3];
                next_s.half = 1'b1;
              end else begin
                next_s.sum = add_eac(s.sum, {s.hist[3], s.low}); // RULE_10 RULE_11
                next_s.half = 1'b0;
              end
            end
          end
          if (rx_byte_in.last) begin
            if (en_eff) begin
              next_s.ready = 1'b0;
              next_s.st = rco_pkg::ST_FOLD;
            end else begin
              next_s.len.valid = 1'b1;
              next_s.len.length = first ? 16'h0001 : next_s.pos;
            end
          end
        end
      end
      rco_pkg::ST_FOLD: begin
        if (s.half) begin
          next_s.sum = add_eac(s.sum, {8'h00, s.low}); // RULE_10
        end
        next_s.half = 1'b0;
        next_s.st = rco_pkg::ST_APP_LO;
      end
      rco_pkg::ST_APP_LO: begin
        next_s.out.valid = 1'b1; // RULE_05
        next_s.out.data = s.sum[7:0]; // RULE_13
        next_s.st = rco_pkg::ST_APP_HI;
      end
      rco_pkg::ST_APP_HI: begin
        next_s.out.valid = 1'b1; // RULE_05
        next_s.out.data = s.sum[15:8];
        next_s.out.last = 1'b1;
        next_s.len.valid = 1'b1;
        next_s.len.length = s.pos + rco_pkg::CSUM_LEN; // RULE_06
        next_s.ready = 1'b1;
        next_s.st = rco_pkg::ST_RUN;
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s <= '0;
      s.st <= rco_pkg::ST_RUN;
      s.ready <= 1'b1;
      s.start <= rco_pkg::START_NONE;
    end else begin
      s <= next_s;
    end
  end

  assign rx_ready_out = s.ready;
  assign dma_byte_out = s.out;
  assign frame_length_field_out = s.len;

endmodule

// ===== sim/rco_dma_model.sv
`timescale 1ns/1ps
// ****
// DMA side byte counter
// ****
module rco_dma_model (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire rco_pkg::rco_byte_s dma_byte_in,
  output logic [15:0] bytes_out
);
  logic [15:0] cnt;
  assign bytes_out = cnt + 16'h0001;
  always @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) cnt <= 16'h0000;
    else if (dma_byte_in.valid) cnt <= dma_byte_in.last ? 16'h0000 : cnt + 16'h0001;
  end
endmodule

// ===== sim/rco_checker.sv
`timescale 1ns/1ps
// ****
// Port relations
// ****
module rco_checker (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire rco_pkg::rco_byte_s rx_byte_in,
  input wire logic rx_ready_out,
  input wire rco_pkg::rco_byte_s dma_byte_out,
  input wire rco_pkg::rco_len_s frame_length_field_out
);
  logic [15:0] cnt;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) cnt <= 16'h0000;
    else if (dma_byte_out.valid) cnt <= dma_byte_out.last ? 16'h0000 : cnt + 16'h0001;
  end
  byte_pass_a: assert property (rx_byte_in.valid && rx_ready_out |=> dma_byte_out.valid &&
    dma_byte_out.data == $past(rx_byte_in.data)) else $error("byte not forwarded");
  end_kind_a: assert property (rx_byte_in.valid && rx_ready_out && rx_byte_in.last |=>
    dma_byte_out.last == rx_ready_out) else $error("frame end kind wrong");
  append_order_a: assert property ($fell(rx_ready_out) |-> dma_byte_out.valid && !dma_byte_out.last
    ##1 !dma_byte_out.valid ##1 dma_byte_out.valid && !dma_byte_out.last ##1 dma_byte_out.last ##1 rx_ready_out)
    else $error("append order wrong");
  last_len_a: assert property (dma_byte_out.last |-> frame_length_field_out.valid) else $error("no length");
  len_last_a: assert property (frame_length_field_out.valid |-> dma_byte_out.last) else $error("stray length");
  len_count_a: assert property (frame_length_field_out.valid |->
    frame_length_field_out.length == cnt + 16'h0001) else $error("length count wrong");
  len_pulse_a: assert property (frame_length_field_out.valid |=> !frame_length_field_out.valid) else $error("long pulse");
  ready_back_a: assert property ($rose(rx_ready_out) |-> dma_byte_out.last) else $error("early ready");
  cover property ($fell(rx_ready_out));
  cover property (frame_length_field_out.valid && rx_ready_out);
  cover property (rx_byte_in.valid && !rx_ready_out);
endmodule
bind rco_rx_checksum_engine rco_checker chk (.mclk_in, .arst_n_in, .rx_byte_in, .rx_ready_out, .dma_byte_out,
  .frame_length_field_out);

// ===== sim/test_rx_checksum_offload.sv
`timescale 1ns/1ps
module test_rx_checksum_offload;
  // ****
  // Stimulus and checking
  // ****
  logic clk, rst_n, en, mode, rdy;
  logic [15:0] tpid, mcount;
  rco_pkg::rco_byte_s rxb, dmab;
  rco_pkg::rco_len_s flen;
  logic [7:0] eb[$], f[$];
  logic [15:0] el[$];
  integer seed = 45, n_fail = 0, num_checks = 0, cyc = 0;
  rco_rx_checksum_engine dut (.mclk_in(clk), .arst_n_in(rst_n), .rx_checksum_enable_in(en),
    .rx_checksum_mode_select_in(mode), .first_vlan_tag_type_in(tpid), .rx_byte_in(rxb),
    .rx_ready_out(rdy), .dma_byte_out(dmab), .frame_length_field_out(flen));
  rco_dma_model dma (.mclk_in(clk), .arst_n_in(rst_n), .dma_byte_in(dmab), .bytes_out(mcount));
  task automatic report_and_stop;
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic build(input int tags, input logic snap, input int pl);
    f.delete();
    repeat (12) f.push_back(8'($random(seed)));
    repeat (tags) f = {f, tpid[15:8], tpid[7:0], 8'($random(seed)), 8'($random(seed))};
    if (snap) f = {f, 8'h00, 8'h40, 8'hAA, 8'hAA, 8'h03, 8'h00, 8'h00, 8'h00};
    else f = {f, 8'h08, 8'h00};
    repeat (pl + 4) f.push_back(8'($random(seed)));
  endtask
  task automatic send(input logic e, input logic m, input logic flip);
    logic [15:0] s, st, p, w;
    logic [16:0] t;
    int n;
    n = f.size();
    st = 16'h000E;
    if (m) begin
      p = 16'h000C;
      for (int k = 0; k < 2 && {f[p], f[p+1]} == tpid; k++) p += 16'h0004;
      st = p + 16'h0002;
      if ({f[p], f[p+1]} < 16'h0600 && f[p+2] == 8'hAA && f[p+3] == 8'hAA && f[p+4] == 8'h03) st = p + 16'h000A;
    end
    s = 16'h0000;
    for (int i = st; i < n - 4; i += 2) begin
      w = {(i + 1 < n - 4) ? f[i+1] : 8'h00, f[i]};
      t = s + w;
      s = t[15:0] + t[16];
    end
    foreach (f[i]) eb.push_back(f[i]);
    if (e) eb = {eb, s[7:0], s[15:8]};
    el.push_back(16'(n + (e ? 2 : 0)));
    foreach (f[i]) begin
      @(negedge clk);
      if ($random(seed) % 4 == 0) begin
        rxb.valid = 1'b0;
        @(negedge clk);
      end
      rxb = '{1'b1, f[i], i == n - 1};
      if (i == 0) {en, mode} = {e, m};
      if (flip && i == 5) {en, mode} = {~e, ~m};
      while (!rdy) @(negedge clk);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(negedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      report_and_stop;
    end
    if (dmab.valid === 1'b1) cmp8(dmab.data, eb.pop_front());
    if (flen.valid === 1'b1) begin
      cmp16(flen.length, el.pop_front());
      cmp16(flen.length, mcount);
    end
  end
  initial begin
    {rst_n, en, mode, tpid, rxb} = {3'b000, 16'h8100, 10'h000};
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    for (int j = 0; j < 64; j++) begin
      if (j == 32) begin
        @(negedge clk);
        rxb.valid = 1'b0;
        repeat (8) @(negedge clk);
        tpid = 16'h88A8;
      end
      build($random(seed) & 3, $random(seed) & 1, $random(seed) & 7);
      send(j[0], j[1], j[2] & j[3]);
    end
    @(negedge clk);
    rxb.valid = 1'b0;
    repeat (20) @(negedge clk);
    report_and_stop;
  end
endmodule
